//--- design/sub_cmp_params.svh
`ifndef SUB_CMP_PARAMS_SVH
`define SUB_CMP_PARAMS_SVH
`define SC_NUM_REGS 8
`define SC_REG_W 24
`define SC_WORD_W 16
`define SC_SP_RESET 24'h000000
`define SC_REG_RESET 24'h000000
`define SC_FLAG_RESET 4'h0
`endif

//--- design/sub_cmp_pkg.sv
`include "sub_cmp_params.svh"
package sub_cmp_pkg;
	typedef enum logic [3:0] {
		op_nop = 4'h0,
		op_suba_reg_imm = 4'h1,
		op_suba_sp_imm = 4'h2,
		op_sbc_reg = 4'h3,
		op_sbc_imm = 4'h4,
		op_cmp_reg = 4'h5,
		op_cmp_imm = 4'h6,
		op_cmpa_reg = 4'h7
	} op_type;
	typedef enum logic [1:0] {
		cond_always = 2'h0,
		cond_carry_set = 2'h1,
		cond_carry_clear = 2'h2
	} cond_type;
	typedef struct packed {
		logic valid;
		op_type op;
		cond_type cond;
		logic [2:0] rd;
		logic [2:0] rs;
		logic [6:0] immediate7;
	} instr_type;
	typedef struct packed {
		logic z;
		logic n;
		logic v;
		logic c;
	} flags_type;
endpackage : sub_cmp_pkg

//--- design/reg_file.sv
`timescale 1ns/1ns
`include "sub_cmp_params.svh"
module reg_file (
	input wire logic i_clock,
	input wire logic i_srst,
	input wire logic [2:0] i_rd_addr_a,
	input wire logic [2:0] i_rd_addr_b,
	input wire logic i_wr_en,
	input wire logic [2:0] i_wr_addr,
	input wire logic [`SC_REG_W-1:0] i_wr_data,
	output logic [`SC_REG_W-1:0] o_rd_data_a,
	output logic [`SC_REG_W-1:0] o_rd_data_b
);
	logic [`SC_REG_W-1:0] mem_q [`SC_NUM_REGS];

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			for (int i = 0; i < `SC_NUM_REGS; i++) begin
				mem_q[i] <= `SC_REG_RESET;
			end
		end else if (i_wr_en) begin
			mem_q[i_wr_addr] <= i_wr_data;
		end
	end

	// Combinational read keeps one-cycle issue; the core latches results.
	assign o_rd_data_a = mem_q[i_rd_addr_a];
	assign o_rd_data_b = mem_q[i_rd_addr_b];
endmodule : reg_file

//--- design/sub_cmp_alu.sv
`timescale 1ns/1ns
`include "sub_cmp_params.svh"
module sub_cmp_alu
	import sub_cmp_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_srst,
	input wire instr_type i_instr,
	output logic o_done,
	output logic o_executed,
	output flags_type o_flags,
	output logic [`SC_REG_W-1:0] o_sp,
	output logic [`SC_REG_W-1:0] o_result,
	input wire logic [2:0] i_peek_addr,
	output logic [`SC_REG_W-1:0] o_peek_data
);
	// ------------------------------------------------------------
	// Operand fetch
	// ------------------------------------------------------------
	logic [`SC_REG_W-1:0] rd_val;
	logic [`SC_REG_W-1:0] rs_val;
	logic wr_en;
	logic [`SC_REG_W-1:0] wr_data;
	flags_type flags_q;
	flags_type flags_d;
	logic [`SC_REG_W-1:0] sp_q;
	logic done_q;
	logic exec_q;
	logic [`SC_REG_W-1:0] result_q;
	logic cond_ok;
	logic [`SC_REG_W-1:0] diff;
	logic borrow;
	logic ovf;
	logic [`SC_REG_W-1:0] opb;
	logic is_wide;
	logic writes_flags;

	reg_file u_regs (
		.i_clock(i_clock),
		.i_srst(i_srst),
		.i_rd_addr_a(i_instr.rd),
		.i_rd_addr_b(i_instr.rs),
		.i_wr_en(wr_en),
		.i_wr_addr(i_instr.rd),
		.i_wr_data(wr_data),
		.o_rd_data_a(rd_val),
		.o_rd_data_b(rs_val)
	);

	// A second copy of the registers, written in step with the first, gives
	// the observation port its own read path without a third read port.
	logic [`SC_REG_W-1:0] peek_a;
	reg_file u_shadow (
		.i_clock(i_clock),
		.i_srst(i_srst),
		.i_rd_addr_a(i_peek_addr),
		.i_rd_addr_b(i_peek_addr),
		.i_wr_en(wr_en),
		.i_wr_addr(i_instr.rd),
		.i_wr_data(wr_data),
		.o_rd_data_a(peek_a),
		.o_rd_data_b()
	);
	assign o_peek_data = peek_a;

	// ------------------------------------------------------------
	// Arithmetic
	// ------------------------------------------------------------
	function automatic logic [`SC_REG_W:0] sub_w(
		input logic [`SC_REG_W-1:0] a,
		input logic [`SC_REG_W-1:0] b,
		input logic cin
	);
		sub_w = {1'b0, a} - {1'b0, b} - {{`SC_REG_W{1'b0}}, cin};
	endfunction : sub_w

	function automatic logic [`SC_REG_W-1:0] zext7(input logic [6:0] v);
		zext7 = {{(`SC_REG_W-7){1'b0}}, v};
	endfunction : zext7

	always_comb begin
		case (i_instr.cond)
			cond_carry_set: cond_ok = flags_q.c;
			cond_carry_clear: cond_ok = ~flags_q.c;
			default: cond_ok = 1'b1;
		endcase
	end

	always_comb begin
		opb = rs_val;
		is_wide = 1'b0;
		case (i_instr.op)
			op_suba_reg_imm: begin
				opb = zext7(i_instr.immediate7);
				is_wide = 1'b1;
			end
			op_suba_sp_imm: begin
				opb = zext7(i_instr.immediate7);
				is_wide = 1'b1;
			end
			op_sbc_imm: opb = zext7(i_instr.immediate7);
			op_cmp_imm: begin
				// Sign-extend the immediate before the 16-bit compare.
				opb = {{(`SC_REG_W-6){i_instr.immediate7[6]}},
					i_instr.immediate7[5:0]};
			end
			op_cmpa_reg: is_wide = 1'b1;
			default: opb = rs_val;
		endcase
	end

	logic [`SC_REG_W:0] wide_res;
	logic [`SC_WORD_W:0] narrow_res;
	logic use_carry;
	logic [`SC_REG_W-1:0] opa;
	assign use_carry = (i_instr.op == op_sbc_reg) || (i_instr.op == op_sbc_imm);
	assign opa = (i_instr.op == op_suba_sp_imm) ? sp_q : rd_val;
	assign wide_res = sub_w(opa, opb, 1'b0);
	assign narrow_res = {1'b0, opa[`SC_WORD_W-1:0]}
		- {1'b0, opb[`SC_WORD_W-1:0]}
		- {{`SC_WORD_W{1'b0}}, use_carry & flags_q.c};

	always_comb begin
		if (is_wide) begin
			diff = wide_res[`SC_REG_W-1:0];
			borrow = wide_res[`SC_REG_W];
			ovf = (opa[`SC_REG_W-1] ^ opb[`SC_REG_W-1])
				& (opa[`SC_REG_W-1] ^ diff[`SC_REG_W-1]);
		end else begin
			diff = {{(`SC_REG_W-`SC_WORD_W){1'b0}},
				narrow_res[`SC_WORD_W-1:0]};
			borrow = narrow_res[`SC_WORD_W];
			ovf = (opa[`SC_WORD_W-1] ^ opb[`SC_WORD_W-1])
				& (opa[`SC_WORD_W-1] ^ diff[`SC_WORD_W-1]);
		end
	end

	// ------------------------------------------------------------
	// Write-back and flags
	// ------------------------------------------------------------
	logic go;
	assign go = i_instr.valid && cond_ok && (i_instr.op != op_nop);

	always_comb begin
		wr_en = 1'b0;
		writes_flags = 1'b0;
		case (i_instr.op)
			op_suba_reg_imm: wr_en = go;
			op_sbc_reg, op_sbc_imm: begin
				wr_en = go;
				writes_flags = 1'b1;
			end
			op_cmp_reg, op_cmp_imm, op_cmpa_reg: writes_flags = 1'b1;
			default: wr_en = 1'b0;
		endcase
	end
	// The 16-bit subtract clears the upper byte of the destination.
	assign wr_data = diff;

	always_comb begin
		flags_d = flags_q;
		if (go && writes_flags) begin
			flags_d.z = is_wide ? (diff == '0)
				: (diff[`SC_WORD_W-1:0] == '0);
			flags_d.n = is_wide ? diff[`SC_REG_W-1]
				: diff[`SC_WORD_W-1];
			flags_d.v = ovf;
			flags_d.c = borrow;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			flags_q <= `SC_FLAG_RESET;
		end else begin
			flags_q <= flags_d;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			sp_q <= `SC_SP_RESET;
		end else if (go && i_instr.op == op_suba_sp_imm) begin
			sp_q <= diff;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			done_q <= 1'b0;
			exec_q <= 1'b0;
			result_q <= '0;
		end else begin
			done_q <= i_instr.valid;
			exec_q <= go;
			if (go) begin
				result_q <= diff;
			end
		end
	end

	assign o_done = done_q;
	assign o_executed = exec_q;
	assign o_flags = flags_q;
	assign o_sp = sp_q;
	assign o_result = result_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence skipped_s;
		i_instr.valid && !cond_ok;
	endsequence

	chk_skip_keeps_flags: assert property (
		@(posedge i_clock) disable iff (i_srst)
		skipped_s |=> (flags_q == $past(flags_q)) && !o_executed && o_done)
		else $error("skipped instruction changed flags");
	chk_cond_carry_set: assert property (
		@(posedge i_clock) disable iff (i_srst)
		i_instr.valid && i_instr.cond == cond_carry_set && !flags_q.c
		|-> !wr_en)
		else $error("carry-set form executed with carry clear");
	chk_cond_carry_clr: assert property (
		@(posedge i_clock) disable iff (i_srst)
		i_instr.valid && i_instr.cond == cond_carry_clear && flags_q.c
		|=> !o_executed)
		else $error("carry-clear form executed with carry set");
	chk_sp_update: assert property (
		@(posedge i_clock) disable iff (i_srst)
		go && i_instr.op == op_suba_sp_imm
		|=> o_sp == $past(sp_q)
			- {17'h00000, $past(i_instr.immediate7)})
		else $error("stack pointer subtract wrong");
	chk_suba_wr: assert property (
		@(posedge i_clock) disable iff (i_srst)
		go && i_instr.op == op_suba_reg_imm
		|-> wr_en && wr_data == rd_val - {17'h00000, i_instr.immediate7})
		else $error("address subtract result wrong");
	chk_sbc_result: assert property (
		@(posedge i_clock) disable iff (i_srst)
		go && i_instr.op == op_sbc_reg
		|-> wr_data[15:0]
			== rd_val[15:0] - rs_val[15:0] - {15'h0000, flags_q.c})
		else $error("subtract with borrow wrong");
	chk_cmp_no_write: assert property (
		@(posedge i_clock) disable iff (i_srst)
		i_instr.op inside {op_cmp_reg, op_cmp_imm, op_cmpa_reg}
		|-> !wr_en)
		else $error("compare wrote a register");
	chk_cmp_borrow: assert property (
		@(posedge i_clock) disable iff (i_srst)
		go && i_instr.op == op_cmp_reg
		|=> o_flags.c == ($past(rd_val[15:0]) < $past(rs_val[15:0])))
		else $error("compare borrow flag wrong");
	chk_cmpa_zero: assert property (
		@(posedge i_clock) disable iff (i_srst)
		go && i_instr.op == op_cmpa_reg
		|=> o_flags.z == ($past(rd_val) == $past(rs_val)))
		else $error("wide compare zero flag wrong");
endmodule : sub_cmp_alu

//--- bench/instr_source.sv
`timescale 1ns/1ns
module instr_source
	import sub_cmp_pkg::*;
(
	input wire logic i_clock,
	output instr_type o_instr
);
	initial o_instr = '0;
	// The instruction stands for exactly one edge, as a decoder issues it.
	task automatic send(input op_type op, input cond_type cond,
		input logic [2:0] rd, input logic [2:0] rs, input logic [6:0] imm);
		instr_type word;
		word = '0;
		word.valid = 1'b1;
		word.op = op;
		word.cond = cond;
		word.rd = rd;
		word.rs = rs;
		word.immediate7 = imm;
		@(posedge i_clock);
		o_instr <= word;
		@(posedge i_clock);
		o_instr.valid <= 1'b0;
	endtask : send
endmodule : instr_source

//--- bench/subtract_compare_alu_ops_tb_top.sv
`timescale 1ns/1ns
module subtract_compare_alu_ops_tb_top;
	import sub_cmp_pkg::*;
	logic i_clock = 1'b0;
	logic i_srst = 1'b1;
	logic [2:0] peek_addr = 3'h0;
	instr_type instr;
	logic done;
	logic executed;
	flags_type flags;
	logic [23:0] sp;
	logic [23:0] result;
	logic [23:0] peek_data;
	int errors = 0;
	int checks = 0;
	always #20 i_clock = ~i_clock;
	instr_source pm_u (.i_clock(i_clock), .o_instr(instr));
	sub_cmp_alu dut_u (.i_clock(i_clock), .i_srst(i_srst), .i_instr(instr),
		.o_done(done), .o_executed(executed), .o_flags(flags),
		.o_sp(sp), .o_result(result), .i_peek_addr(peek_addr),
		.o_peek_data(peek_data));
	// ------------------------------------------------------------
	// Shared checking
	// ------------------------------------------------------------
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wrap_up();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : wrap_up
	// Flags are compared as {z, n, v, c}.
	task automatic go(input op_type op, input cond_type cond,
		input logic [2:0] rd, input logic [2:0] rs, input logic [6:0] imm,
		input logic ex_exec, input logic [3:0] ex_flags);
		pm_u.send(op, cond, rd, rs, imm);
		#1;
		check({23'h0, done}, 24'h000001);
		check({23'h0, executed}, {23'h0, ex_exec});
		check({20'h0, flags}, {20'h0, ex_flags});
	endtask : go
	task automatic peek(input logic [2:0] addr, input logic [23:0] exp);
		@(posedge i_clock);
		peek_addr <= addr;
		#1;
		check(peek_data, exp);
	endtask : peek
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		check(sp, 24'h000000);
		check({20'h0, flags}, 24'h000000);
		peek(3'h5, 24'h000000);
		$display("test reset done");
	endtask : t_reset
	task automatic t_addr_sub();
		go(op_suba_reg_imm, cond_always, 3'h1, 3'h0, 7'h05, 1'b1, 4'h0);
		peek(3'h1, 24'hfffffb);
		go(op_suba_sp_imm, cond_always, 3'h0, 3'h0, 7'h7f, 1'b1, 4'h0);
		check(sp, 24'hffff81);
		go(op_suba_reg_imm, cond_always, 3'h2, 3'h0, 7'h7f, 1'b1, 4'h0);
		peek(3'h2, 24'hffff81);
		$display("test address subtract done");
	endtask : t_addr_sub
	task automatic t_sbc();
		go(op_sbc_reg, cond_always, 3'h1, 3'h2, 7'h00, 1'b1, 4'h0);
		check(result, 24'h00007a);
		peek(3'h1, 24'h00007a);
		go(op_sbc_imm, cond_always, 3'h3, 3'h0, 7'h01, 1'b1, 4'h5);
		peek(3'h3, 24'h00ffff);
		go(op_sbc_imm, cond_always, 3'h3, 3'h0, 7'h00, 1'b1, 4'h4);
		peek(3'h3, 24'h00fffe);
		$display("test subtract with borrow done");
	endtask : t_sbc
	task automatic t_cond();
		go(op_sbc_reg, cond_carry_set, 3'h1, 3'h2, 7'h00, 1'b0, 4'h4);
		peek(3'h1, 24'h00007a);
		go(op_cmp_imm, cond_always, 3'h0, 3'h0, 7'h01, 1'b1, 4'h5);
		go(op_cmp_reg, cond_carry_clear, 3'h0, 3'h0, 7'h00, 1'b0, 4'h5);
		go(op_cmp_reg, cond_carry_set, 3'h0, 3'h0, 7'h00, 1'b1, 4'h8);
		go(op_cmpa_reg, cond_carry_clear, 3'h1, 3'h2, 7'h00, 1'b1, 4'h1);
		peek(3'h1, 24'h00007a);
		$display("test conditional execution done");
	endtask : t_cond
	task automatic t_cmp();
		go(op_cmp_imm, cond_always, 3'h0, 3'h0, 7'h40, 1'b1, 4'h1);
		peek(3'h0, 24'h000000);
		go(op_cmp_reg, cond_always, 3'h2, 3'h1, 7'h00, 1'b1, 4'h4);
		peek(3'h2, 24'hffff81);
		go(op_nop, cond_always, 3'h2, 3'h1, 7'h7f, 1'b0, 4'h4);
		peek(3'h2, 24'hffff81);
		$display("test compare done");
	endtask : t_cmp
	initial begin
		repeat (5) @(posedge i_clock);
		i_srst <= 1'b0;
		#1;
		t_reset();
		t_addr_sub();
		t_sbc();
		t_cond();
		t_cmp();
		wrap_up();
	end
	// Whole run takes about forty-five cycles; a hang is cut at three thousand.
	initial begin
		#(40 * 3000);
		errors++;
		$display("MISMATCH at %0t: run did not finish", $time);
		wrap_up();
	end
endmodule : subtract_compare_alu_ops_tb_top
